// ---- hdl/ipdc_core.v ----
// Purpose: priority, vectoring and daisy chain core of a 16-channel interrupt controller
// Assumes: axi4-lite slave for registers; acknowledge pins synchronous to CLK_SYS
// Notes: channel bit index is its channel code; upper register holds codes 15..8
//        strobes must rise between two acknowledge cycles
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "ipdc_map.vh"
module ipdc_core #(
  parameter NCH = 16
) (
  input wire CLK_SYS,
  input wire RST_B,
  input wire [NCH-1:0] CHANNEL_EVENT,
  input wire INTERRUPT_ACKNOWLEDGE_STROBE_B,
  input wire DATA_STROBE_B,
  input wire CHAIN_PRIORITY_IN_B,
  output wire CHAIN_PRIORITY_OUT_B,
  output wire INTERRUPT_REQUEST_B,
  output wire [7:0] VECTOR_DATA_OUT,
  output wire VECTOR_DATA_OE,
  output wire TRANSFER_ACKNOWLEDGE_B_OUT,
  output wire TRANSFER_ACKNOWLEDGE_OE,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  // acknowledge cycle states
  localparam ST_IDLE = 2'd0;
  localparam ST_ANSWER = 2'd1;
  localparam ST_PASS = 2'd2;
  localparam ST_WAIT = 2'd3;

  // channel registers, one bit per channel code, then the vector register
  reg [NCH-1:0] enable_reg;
  reg [NCH-1:0] pending_reg;
  reg [NCH-1:0] inservice_reg;
  reg [NCH-1:0] mask_reg;
  reg [7:0] vector_reg;

  // acknowledge cycle state and the latched vector
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] vec_out_reg;

  // axi bookkeeping: held halves of a write, registered answers
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  // the vector register resets with the software end bit set, so in-service
  // tracking is live until software writes the vector register with that bit clear
  wire soft_eoi = vector_reg[`IPDC_VECTOR_SOFT_EOI_BIT];
  wire ack_active = ~INTERRUPT_ACKNOWLEDGE_STROBE_B & ~DATA_STROBE_B;
  wire [NCH-1:0] block;
  wire [NCH-1:0] service_req;
  wire [3:0] top_code;
  wire top_found;

  // a channel is blocked by any in-service bit at its own code or above
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_blk
      assign block[g] = soft_eoi & (|(inservice_reg >> g));
    end
  endgenerate

  // masking only gates the request, pending keeps collecting
  assign service_req = enable_reg & pending_reg & mask_reg & ~block;

  // code equals bit index: 15 line seven, 14 line six, 13 timer A,
  // 12 receive full, 11 receive error, 10 transmit empty, 9 transmit error,
  // 8 timer B, 7 line five, 6 line four, 5 timer C, 4 timer D,
  // 3 to 0 lines three to zero; the sources wire events to these bits
  ipdc_prio_enc #(.N(NCH), .W(4)) u_enc (
    .req(service_req),
    .code(top_code),
    .found(top_found)
  );

  // request follows the encoder directly, no extra cycle of delay
  assign INTERRUPT_REQUEST_B = ~top_found;

  // acknowledge decision: answer when chain input asserted and service needed
  // the decision is taken once, at entry, so a request that arrives mid cycle
  // cannot change which device answers or which vector goes out
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ack_active && !CHAIN_PRIORITY_IN_B) begin
          state_next = top_found ? ST_ANSWER : ST_PASS;
        end
      end
      ST_ANSWER: begin
        state_next = ST_WAIT;
      end
      ST_PASS: begin
        if (!ack_active || CHAIN_PRIORITY_IN_B) state_next = ST_IDLE;
      end
      ST_WAIT: begin
        if (!ack_active) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // vector latched at entry so it stands stable through the cycle
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= ST_IDLE;
      vec_out_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && state_next == ST_ANSWER) begin
        vec_out_reg <= {vector_reg[7:4], top_code};
      end
    end
  end

  // data placed one cycle before transfer acknowledge, released when strobes rise
  assign VECTOR_DATA_OUT = vec_out_reg;
  assign VECTOR_DATA_OE = (state_reg == ST_ANSWER) || (state_reg == ST_WAIT);
  assign TRANSFER_ACKNOWLEDGE_OE = VECTOR_DATA_OE;
  assign TRANSFER_ACKNOWLEDGE_B_OUT = ~(state_reg == ST_WAIT);
  // chain passes only while not answering; are wiring outside
  assign CHAIN_PRIORITY_OUT_B = ~(state_reg == ST_PASS);

  // axi write: address and data latched in any order, then one response
  // readies stay low while a response waits, so a second write cannot slip
  // in ahead of the first one's answer
  wire aw_take = S_AXI_AWVALID & ~aw_hold_reg & ~bvalid_reg;
  wire w_take = S_AXI_WVALID & ~w_hold_reg & ~bvalid_reg;
  assign S_AXI_AWREADY = ~aw_hold_reg & ~bvalid_reg;
  assign S_AXI_WREADY = ~w_hold_reg & ~bvalid_reg;
  wire [7:0] wr_addr = aw_hold_reg ? awaddr_reg : S_AXI_AWADDR;
  wire [31:0] wr_data = w_hold_reg ? wdata_reg : S_AXI_WDATA;
  wire [3:0] wr_strb = w_hold_reg ? wstrb_reg : S_AXI_WSTRB;
  wire wr_fire = (aw_hold_reg | aw_take) & (w_hold_reg | w_take);
  // only byte lane zero carries register data; other lanes are ignored
  wire wr_lane = wr_strb[0];
  wire [7:0] wb = wr_data[7:0];
  // unmapped addresses answer with an error and change nothing
  wire wr_hit = (wr_addr == `IPDC_OFF_ENABLE_UPPER) || (wr_addr == `IPDC_OFF_ENABLE_LOWER) ||
    (wr_addr == `IPDC_OFF_PENDING_UPPER) || (wr_addr == `IPDC_OFF_PENDING_LOWER) ||
    (wr_addr == `IPDC_OFF_INSERVICE_UPPER) || (wr_addr == `IPDC_OFF_INSERVICE_LOWER) ||
    (wr_addr == `IPDC_OFF_MASK_UPPER) || (wr_addr == `IPDC_OFF_MASK_LOWER) ||
    (wr_addr == `IPDC_OFF_VECTOR);
  wire we = wr_fire & wr_lane;

  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `IPDC_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `IPDC_RESP_OKAY : `IPDC_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_hold_reg <= 1'b1;
          awaddr_reg <= S_AXI_AWADDR;
        end
        if (w_take) begin
          w_hold_reg <= 1'b1;
          wdata_reg <= S_AXI_WDATA;
          wstrb_reg <= S_AXI_WSTRB;
        end
        if (bvalid_reg && S_AXI_BREADY) bvalid_reg <= 1'b0;
      end
    end
  end
  // write response straight from its flip-flops
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  // write masks for register fields, upper byte holds codes 15..8
  wire wen_eu = we && wr_addr == `IPDC_OFF_ENABLE_UPPER;
  wire wen_el = we && wr_addr == `IPDC_OFF_ENABLE_LOWER;
  wire wen_pu = we && wr_addr == `IPDC_OFF_PENDING_UPPER;
  wire wen_pl = we && wr_addr == `IPDC_OFF_PENDING_LOWER;
  wire wen_su = we && wr_addr == `IPDC_OFF_INSERVICE_UPPER;
  wire wen_sl = we && wr_addr == `IPDC_OFF_INSERVICE_LOWER;
  wire wen_mu = we && wr_addr == `IPDC_OFF_MASK_UPPER;
  wire wen_ml = we && wr_addr == `IPDC_OFF_MASK_LOWER;
  wire wen_vec = we && wr_addr == `IPDC_OFF_VECTOR;

  // next enable value, used by the pending and event logic below
  wire [NCH-1:0] enable_new = {wen_eu ? wb : enable_reg[15:8],
                               wen_el ? wb : enable_reg[7:0]};
  // a zero written to pending clears; a one leaves the bit alone
  wire [NCH-1:0] pend_keep = {wen_pu ? wb : 8'hff, wen_pl ? wb : 8'hff};
  wire [NCH-1:0] isr_keep = {wen_su ? wb : 8'hff, wen_sl ? wb : 8'hff};
  wire answer_now = (state_reg == ST_IDLE) && (state_next == ST_ANSWER);
  // one-hot of the channel being answered, empty outside an answer
  wire [NCH-1:0] ack_hit = answer_now ? ({{(NCH-1){1'b0}}, 1'b1} << top_code) : {NCH{1'b0}};
  wire [NCH-1:0] new_event = CHANNEL_EVENT & enable_new;

  // channel state updates; new events win over same-cycle write and acknowledge clears, not over disable
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      enable_reg <= {NCH{1'b0}};
      pending_reg <= {NCH{1'b0}};
      inservice_reg <= {NCH{1'b0}};
    end else begin
      enable_reg <= enable_new;
      // disable clears pending, acknowledge clears the answered bit
      pending_reg <= (pending_reg & pend_keep & enable_new & ~ack_hit) | new_event;
      // in-service ignores enable changes; set only in software end mode
      inservice_reg <= (inservice_reg & isr_keep) |
                       (soft_eoi ? ack_hit : {NCH{1'b0}});
    end
  end

  // masks and vector base only change by register write
  // masks reset to zero, so every channel starts masked until software opens it
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      mask_reg <= {NCH{1'b0}};
      vector_reg <= `IPDC_VECTOR_RESET;
    end else begin
      if (wen_mu) begin
        mask_reg[15:8] <= wb;
      end
      if (wen_ml) begin
        mask_reg[7:0] <= wb;
      end
      // the low three bits are written as zero and always read as zero
      if (wen_vec) begin
        vector_reg <= {wb[7:4], wb[3], 3'b000};
      end
    end
  end

  // axi read: one outstanding, data registered
  assign S_AXI_ARREADY = ~rvalid_reg;
  // read mux over the byte-wide registers
  reg [7:0] rd_byte;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (S_AXI_ARADDR)
      `IPDC_OFF_ENABLE_UPPER: rd_byte = enable_reg[15:8];
      `IPDC_OFF_ENABLE_LOWER: rd_byte = enable_reg[7:0];
      `IPDC_OFF_PENDING_UPPER: rd_byte = pending_reg[15:8];
      `IPDC_OFF_PENDING_LOWER: rd_byte = pending_reg[7:0];
      `IPDC_OFF_INSERVICE_UPPER: rd_byte = inservice_reg[15:8];
      `IPDC_OFF_INSERVICE_LOWER: rd_byte = inservice_reg[7:0];
      `IPDC_OFF_MASK_UPPER: rd_byte = mask_reg[15:8];
      `IPDC_OFF_MASK_LOWER: rd_byte = mask_reg[7:0];
      `IPDC_OFF_VECTOR: rd_byte = {vector_reg[7:3], 3'b000};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read answer registered; the address is decoded in the cycle it is taken
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `IPDC_RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= {24'h000000, rd_byte};
        rresp_reg <= rd_hit ? `IPDC_RESP_OKAY : `IPDC_RESP_SLVERR;
      end else if (rvalid_reg && S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  // read answer straight from its flip-flops
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
endmodule // ipdc_core
`default_nettype wire

// ---- hdl/ipdc_map.vh ----
// Purpose: constants for the interrupt priority and daisy chain core
// Assumes: axi4-lite register access, 32-bit data, one word per register
// Notes: byte offsets below are the register addresses on the bus
//
// Functional notes
// - sixteen channels ranked fixed; general line seven code 1111 highest, line zero 0000 lowest.
// - line6 1110, timer A 1101, rx full 1100, rx err 1011, tx empty 1010, tx err 1001, timer B 1000.
// - line5 0111, line4 0110, timer C 0101, timer D 0100, lines 3,2,1 are 0011,0010,0001.
// - vector upper nibble copied from upper nibble of the vector register.
// - vector lower nibble is code of highest-priority requesting channel.
// - acknowledge with chain input asserted: answer vector if needing service, else pass on.
// - a device that supplies a vector keeps its chain output deasserted.
// - each channel has an enable bit; one enables, zero disables.
// - enable registers read back stored bits at any time.
// - event on enabled channel sets pending bit and raises request output.
// - events on disabled channels are ignored entirely.
// - writing zero to enable bit clears matching pending bit.
// - disabling a channel leaves its in-service bit unchanged.
// - vectored answer clears the answered channel's pending bit.
// - pending write clears bits written zero, keeps bits written one.
// - writing all ones leaves pending unchanged; writes never set pending.
// - with acknowledge and data strobe, drive vector on low data then transfer acknowledge.
// - a device passing the chain drives neither data nor transfer acknowledge.
// - masked channel still sets pending but raises no request.
// - software end mode: in-service bit blocks lower channels from request and vector.
`ifndef IPDC_MAP_VH
`define IPDC_MAP_VH
`define IPDC_OFF_ENABLE_UPPER 8'h00
`define IPDC_OFF_ENABLE_LOWER 8'h04
`define IPDC_OFF_PENDING_UPPER 8'h08
`define IPDC_OFF_PENDING_LOWER 8'h0c
`define IPDC_OFF_INSERVICE_UPPER 8'h10
`define IPDC_OFF_INSERVICE_LOWER 8'h14
`define IPDC_OFF_MASK_UPPER 8'h18
`define IPDC_OFF_MASK_LOWER 8'h1c
`define IPDC_OFF_VECTOR 8'h20
`define IPDC_VECTOR_RESET 8'h0f
`define IPDC_VECTOR_SOFT_EOI_BIT 3
`define IPDC_RESP_OKAY 2'b00
`define IPDC_RESP_SLVERR 2'b10
`endif

// ---- hdl/ipdc_prio_enc.v ----
// Purpose: fixed priority encoder over sixteen channel requests
// Assumes: bit index equals channel code
// Notes: purely combinational; found is low when no bit is set
`timescale 1ns/1ns
`default_nettype none
module ipdc_prio_enc #(
  parameter N = 16,
  parameter W = 4
) (
  input wire [N-1:0] req,
  output reg [W-1:0] code,
  output reg found
);
  integer i;
  // scan upward so the highest index wins
  always @* begin
    code = {W{1'b0}};
    found = 1'b0;
    for (i = 0; i < N; i = i + 1) begin
      if (req[i]) begin
        code = i[W-1:0];
        found = 1'b1;
      end
    end
  end
endmodule // ipdc_prio_enc
`default_nettype wire

// ---- testbench/ipdc_core_monitor.sv ----
// Purpose: acknowledge and chain checks at the core ports
// Assumes: host holds strobes until answered
// Notes: bound into every core
`timescale 1ns/1ns
`default_nettype none
module ipdc_core_monitor (
  input wire CLK_SYS,
  input wire RST_B,
  input wire INTERRUPT_ACKNOWLEDGE_STROBE_B,
  input wire DATA_STROBE_B,
  input wire CHAIN_PRIORITY_IN_B,
  input wire CHAIN_PRIORITY_OUT_B,
  input wire INTERRUPT_REQUEST_B,
  input wire [7:0] VECTOR_DATA_OUT,
  input wire VECTOR_DATA_OE,
  input wire TRANSFER_ACKNOWLEDGE_B_OUT,
  input wire TRANSFER_ACKNOWLEDGE_OE
);
  // both strobes low, and nothing driven yet
  wire ack_on = !INTERRUPT_ACKNOWLEDGE_STROBE_B && !DATA_STROBE_B;
  wire idle = !VECTOR_DATA_OE && CHAIN_PRIORITY_OUT_B;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  sequence s_take;
    ack_on && !CHAIN_PRIORITY_IN_B && idle;
  endsequence
  sequence s_answer;
    VECTOR_DATA_OE && TRANSFER_ACKNOWLEDGE_OE ##1 !TRANSFER_ACKNOWLEDGE_B_OUT;
  endsequence
  a_ack_answer: assert property (s_take ##0 !INTERRUPT_REQUEST_B |=> s_answer)
    else $error("vector answer missing");
  a_ack_pass: assert property (s_take ##0 INTERRUPT_REQUEST_B |=> !CHAIN_PRIORITY_OUT_B)
    else $error("chain not passed on");
  a_vec_blocks: assert property (VECTOR_DATA_OE |-> CHAIN_PRIORITY_OUT_B)
    else $error("chain out low while answering");
  a_pass_quiet: assert property (!CHAIN_PRIORITY_OUT_B |-> !VECTOR_DATA_OE && !TRANSFER_ACKNOWLEDGE_OE)
    else $error("bus driven while passing");
  a_chain_off: assert property (CHAIN_PRIORITY_IN_B && idle |=> idle)
    else $error("answer without chain input");
  a_ack_release: assert property (VECTOR_DATA_OE && !ack_on |=> !VECTOR_DATA_OE && !TRANSFER_ACKNOWLEDGE_OE)
    else $error("bus kept after strobes rose");
  a_vec_hold: assert property (VECTOR_DATA_OE && $past(VECTOR_DATA_OE) |-> $stable(VECTOR_DATA_OUT))
    else $error("vector changed mid answer");
  a_tack_hold: assert property (TRANSFER_ACKNOWLEDGE_OE && !TRANSFER_ACKNOWLEDGE_B_OUT && ack_on |=> !TRANSFER_ACKNOWLEDGE_B_OUT)
    else $error("transfer acknowledge dropped early");
endmodule // ipdc_core_monitor
bind ipdc_core ipdc_core_monitor u_mon (
  .CLK_SYS(CLK_SYS),
  .RST_B(RST_B),
  .INTERRUPT_ACKNOWLEDGE_STROBE_B(INTERRUPT_ACKNOWLEDGE_STROBE_B),
  .DATA_STROBE_B(DATA_STROBE_B),
  .CHAIN_PRIORITY_IN_B(CHAIN_PRIORITY_IN_B),
  .CHAIN_PRIORITY_OUT_B(CHAIN_PRIORITY_OUT_B),
  .INTERRUPT_REQUEST_B(INTERRUPT_REQUEST_B),
  .VECTOR_DATA_OUT(VECTOR_DATA_OUT),
  .VECTOR_DATA_OE(VECTOR_DATA_OE),
  .TRANSFER_ACKNOWLEDGE_B_OUT(TRANSFER_ACKNOWLEDGE_B_OUT),
  .TRANSFER_ACKNOWLEDGE_OE(TRANSFER_ACKNOWLEDGE_OE)
);
`default_nettype wire

// ---- testbench/ipdc_chain_peer.sv ----
// Purpose: higher priority peer controller in the chain
// Assumes: its own chain input tied low, top of chain
// Notes: slow adds two cycles before passing on
`timescale 1ns/1ns
`default_nettype none
module ipdc_chain_peer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ack_b,
  input wire logic has_req,
  input wire logic slow,
  output var logic out_b
);
  logic [1:0] cnt;
  // shared acknowledge seen by every peer; pass down only when idle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 2'h0;
      out_b <= 1'b1;
    end else if (ack_b || has_req) begin
      cnt <= 2'h0;
      out_b <= 1'b1;
    end else begin
      if (cnt != 2'h3)
        cnt <= cnt + 2'h1;
      out_b <= !(cnt >= (slow ? 2'h2 : 2'h0));
    end
  end
endmodule // ipdc_chain_peer
`default_nettype wire

// ---- testbench/ipdc_core_tb_top.sv ----
// Purpose: self-checking bench for the interrupt core
// Assumes: one upstream peer drives the chain input
// Notes: lfsr seed fixed so runs repeat
`timescale 1ns/1ns
`default_nettype none
module ipdc_core_tb_top;
  logic clk = 0, rst_b = 0, interrupt_acknowledge_strobe_b = 1, ds_b = 1, p_req = 0, p_slow = 0;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [3:0] ws = 4'hf;
  logic [15:0] ev_v = 0, v;
  logic [7:0] awa = 0, ara = 0, vd, g;
  logic [31:0] wd = 0, rdat, d, r = 32'd92956;
  logic [1:0] bresp, rresp, rs, a;
  logic awr, wr_r, bv, arr, rv, cin_b, cout_b, irq_b, voe, tack_b, toe;
  int n_errors = 0, check_count = 0;
  ipdc_core dut (.CLK_SYS(clk), .RST_B(rst_b), .CHANNEL_EVENT(ev_v),
    .INTERRUPT_ACKNOWLEDGE_STROBE_B(interrupt_acknowledge_strobe_b), .DATA_STROBE_B(ds_b),
    .CHAIN_PRIORITY_IN_B(cin_b), .CHAIN_PRIORITY_OUT_B(cout_b),
    .INTERRUPT_REQUEST_B(irq_b), .VECTOR_DATA_OUT(vd), .VECTOR_DATA_OE(voe),
    .TRANSFER_ACKNOWLEDGE_B_OUT(tack_b), .TRANSFER_ACKNOWLEDGE_OE(toe),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr));
  ipdc_chain_peer peer (.clk(clk), .rst_b(rst_b), .ack_b(interrupt_acknowledge_strobe_b), .has_req(p_req),
    .slow(p_slow), .out_b(cin_b));
  // 10 MHz clock
  initial forever #50 clk = ~clk;
  // hang guard, well beyond the planned run
  initial begin
    #(100 * 20000);
    n_errors++;
    finish_test;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] hi(input logic [15:0] x);
    hi = 4'h0;
    for (int k = 0; k < 16; k++)
      if (x[k]) hi = k[3:0];
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] x);
    check_count++;
    if (x !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, x);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] dt);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    awa <= ad;
    wd <= dt;
    awv <= 1;
    wv <= 1;
    br <= 1;
    while (!(aw && w)) begin
      @(posedge clk);
      aw = aw | awr;
      w = w | wr_r;
      if (aw) awv <= 0;
      if (w) wv <= 0;
    end
    while (!bv) @(posedge clk);
    rs = bresp;
    br <= 0;
  endtask
  task rd(input logic [7:0] ad);
    @(posedge clk);
    ara <= ad;
    arv <= 1;
    rr <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    do @(posedge clk); while (!rv);
    d = rdat;
    rs = rresp;
    rr <= 0;
  endtask
  // one-cycle event pulse, then let the request settle
  task ev(input logic [15:0] x);
    @(posedge clk);
    ev_v <= x;
    @(posedge clk);
    ev_v <= 0;
    @(posedge clk);
  endtask
  task ack;
    int n;
    n = 0;
    @(posedge clk);
    interrupt_acknowledge_strobe_b <= 0;
    ds_b <= 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(voe && !tack_b) && cout_b && n < 8);
    a = {voe, !cout_b};
    g = vd;
    interrupt_acknowledge_strobe_b <= 1;
    ds_b <= 1;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1;
    rd(8'h20);
    chk("vec_reset", 32'h08, d);
    rd(8'h40);
    chk("unmapped", 32'h2, rs);
    r = lfsr(r);
    wr(8'h04, {24'h0, r[7:0]});
    chk("wr_okay", 0, rs);
    rd(8'h04);
    chk("enable", {24'h0, r[7:0]}, d);
    ws <= 4'h0;
    wr(8'h04, 32'h0);
    ws <= 4'hf;
    chk("strb_resp", 0, rs);
    rd(8'h04);
    chk("strb_off", {24'h0, r[7:0]}, d);
    wr(8'h40, 32'hff);
    chk("wr_unmapped", 2, rs);
    wr(8'h20, 32'ha0);
    wr(8'h18, 32'hff);
    wr(8'h1c, 32'hff);
    wr(8'h00, 32'hff);
    wr(8'h04, 32'hff);
    for (int i = 0; i < 16; i++) begin
      ev(16'h1 << i);
      chk("irq", 0, irq_b);
      ack;
      chk("vector", {22'h0, 2'b10, 4'ha, i[3:0]}, {22'h0, a, g});
      rd(i < 8 ? 8'h0c : 8'h08);
      chk("pend_ack", 0, d);
    end
    for (int k = 0; k < 4; k++) begin
      r = lfsr(r);
      v = r[15:0] | 16'h1;
      ev(v);
      while (v != 0) begin
        ack;
        chk("prio", {4'ha, hi(v)}, g);
        v[hi(v)] = 0;
      end
    end
    r = lfsr(r);
    ev(16'hffff);
    wr(8'h0c, {24'h0, r[7:0]});
    rd(8'h0c);
    chk("pend_clr", {24'h0, r[7:0]}, d);
    wr(8'h08, 32'hff);
    rd(8'h08);
    chk("pend_ones", 32'hff, d);
    wr(8'h08, 0);
    wr(8'h0c, 0);
    ev(16'h0100);
    wr(8'h00, 32'hfe);
    rd(8'h08);
    chk("dis_clr", 0, d);
    chk("irq_dis", 1, irq_b);
    ev(16'h0100);
    rd(8'h08);
    chk("dis_ign", 0, d);
    wr(8'h00, 32'hff);
    wr(8'h1c, 0);
    ev(16'h0001);
    rd(8'h0c);
    chk("masked", 32'h3, {d[30:0], irq_b});
    wr(8'h0c, 0);
    wr(8'h1c, 32'hff);
    p_req <= 1;
    ev(16'h0004);
    ack;
    chk("chain_hi", 0, a);
    p_req <= 0;
    wr(8'h0c, 0);
    p_slow <= 1;
    ack;
    chk("chain_pass", 1, a);
    wr(8'h20, 32'ha8);
    ev(16'h0200);
    ack;
    chk("soft_vec", 32'ha9, g);
    ev(16'h0008);
    chk("blocked", 1, irq_b);
    ack;
    chk("blk_pass", 1, a);
    wr(8'h00, 32'hfd);
    rd(8'h10);
    chk("insvc", 32'h2, d);
    wr(8'h10, 32'hfd);
    wr(8'h00, 32'hff);
    chk("unblock", 0, irq_b);
    ack;
    chk("low_vec", 32'ha3, g);
    finish_test;
  end
endmodule // ipdc_core_tb_top
`default_nettype wire
